// ==== src_cfg.svh ====
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH
// =====================================
// timing
`define SRC_CLK_PERIOD_NS 100
`define SRC_FILT_NS       60
`define SRC_FILT_CYC      ((`SRC_FILT_NS + `SRC_CLK_PERIOD_NS - 1) / `SRC_CLK_PERIOD_NS)
// =====================================
// cpu reset values
`define SRC_GPR0_RST      32'h0000_0000
`define SRC_PC_RST        32'h0000_0000
`define SRC_ISC_RST       32'h0000_0000
`define SRC_PSW_RST       32'h0000_0020
// =====================================
// port reset values
`define SRC_PDIR_RST      8'hFF
`define SRC_PMC_RST       8'h00
`define SRC_PORT2_FUNCTION_SELECT_RST      8'h01
`define SRC_PMCS_BUS_RST  8'hFF
`define SRC_PMCM_BUS_RST  8'h3F
`define SRC_PMCM_CLK_BIT  1
// =====================================
// peripheral reset values
`define SRC_INTC_RST      8'h47
`define SRC_IMR_RST       16'hFFFF
`define SRC_DWC_RST       16'h7777
`define SRC_CSC_RST       16'h2C11
`define SRC_ASC_RST       16'hFFFF
`define SRC_FLPM_SC0_RST  8'h08
`define SRC_FLPM_OTH_RST  8'h0C
`define SRC_FLPM_ROM_RST  8'h00
`define SRC_CONVERTER_MODE_SECOND_RST      8'h07
`define SRC_PWMC_RST      8'h40
`define SRC_TMC1_RST      8'h20
`define SRC_TCNT_RST      16'h0000
`endif

// ==== src_pkg.sv ====
`default_nettype none
// =====================================
// shared types
package src_pkg;
  // operating mode strap
  typedef enum logic [1:0] {
    SRC_SC0 = 2'b00,
    SRC_SC1 = 2'b01,
    SRC_RL0 = 2'b10,
    SRC_RL1 = 2'b11
  } src_mode_t;
  // sequencer state
  typedef enum logic [0:0] {
    SRC_HOLD = 1'b0,
    SRC_RUN  = 1'b1
  } src_state_t;
  // register select for write and read
  typedef enum logic [3:0] {
    SRC_R_PC   = 4'h0,
    SRC_R_ISC  = 4'h1,
    SRC_R_PSW  = 4'h2,
    SRC_R_PDIR = 4'h3,
    SRC_R_PORT2_FUNCTION_SELECT = 4'h4,
    SRC_R_PMCM = 4'h5,
    SRC_R_PMCS = 4'h6,
    SRC_R_INTC = 4'h7,
    SRC_R_IMR  = 4'h8,
    SRC_R_DWC  = 4'h9,
    SRC_R_CSC  = 4'hA,
    SRC_R_ASC  = 4'hB,
    SRC_R_FLPM = 4'hC,
    SRC_R_PERI = 4'hD,
    SRC_R_TCNT = 4'hE,
    SRC_R_GPR0 = 4'hF
  } src_reg_t;
endpackage
`default_nettype wire

// ==== src_filter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "src_cfg.svh"
// =====================================
// reset pin noise filter and synchroniser
module src_filter import src_pkg::*; #(
  parameter int FILT_CYC = `SRC_FILT_CYC      // low samples needed
) (
  input  wire logic sys_clk,                  // core clock
  input  wire logic reset_n,                  // block reset
  input  wire logic rst_pin_n,                // external reset pin
  output var  logic rst_req                   // filtered, synced, high = reset
);
  // refuse counts the 8 bit counter cannot serve
  if (FILT_CYC < 1 || FILT_CYC > 255) begin : g_bad_filt
    $error("FILT_CYC out of range");
  end

  logic [7:0] cnt;                            // consecutive low samples
  logic       filt_low;                       // filtered pin low
  logic       sync1;                          // first sync stage

  // =====================================
  // glitch filter
  // reject short lows
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt      <= 8'h00;
      filt_low <= 1'b1;
    end else if (rst_pin_n) begin
      cnt      <= 8'h00;                      // high releases at once
      filt_low <= 1'b0;
    end else if (cnt == 8'(FILT_CYC - 1)) begin
      filt_low <= 1'b1;                       // low long enough
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // =====================================
  // two stage synchroniser
  // align to clock
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1   <= 1'b1;
      rst_req <= 1'b1;
    end else begin
      sync1   <= filt_low;
      rst_req <= sync1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_filter_glitch: assert property (rst_pin_n |=> !filt_low)
    else $error("filter held low after pin high");
  a_filter_accept: assert property (!rst_pin_n && cnt == 8'(FILT_CYC - 1) |=> filt_low)
    else $error("filter missed a long low");
  a_sync_delay: assert property (filt_low |-> ##2 rst_req)
    else $error("sync stage delay wrong");
endmodule // src_filter
`default_nettype wire

// ==== src_reset_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "src_cfg.svh"
module src_reset_ctrl import src_pkg::*; #(
  parameter bit FLASH_PART = 1'b1             // variant with flash array
) (
  input  wire logic        sys_clk,           // core clock, 10 MHz
  input  wire logic        reset_n,           // block reset
  input  wire logic        rst_pin_n,         // external reset pin
  input  wire logic [1:0]  mode_strap,        // operating mode pins
  input  wire logic        sync_wr_busy,      // synchronised write underway
  input  wire logic        sw_wr,             // software write strobe
  input  wire logic [3:0]  sw_sel,            // register select
  input  wire logic [31:0] sw_data,           // write data
  output var  logic [31:0] rd_data,           // read data of sw_sel
  output var  logic        core_reset_n,      // chip wide reset
  output var  logic        fetch_start,       // pulse, cpu begins fetch
  output var  logic        pin_hiz,           // ordinary pins high impedance
  output var  logic        bus_port_mode,     // bus pins in port mode
  output var  logic        bus_ports_ctrl,    // bus ports in control mode
  output var  logic        clock_output_pin,  // clock pin level
  output logic             clock_output_oe_n, // low while clock pin driven
  output var  logic        contents_kept      // undefined regs still valid
);
  // =====================================
  // declarations
  logic       hold;                           // synced reset request
  src_state_t state;                          // sequencer state
  src_state_t next_state;                     // next sequencer state
  src_mode_t  mode;                           // captured mode
  logic       wr_ok;                          // write allowed
  logic [31:0] program_counter;               // pc
  logic [31:0] interrupt_source_code;         // exception cause
  logic [31:0] processor_status_word;         // status word
  logic [7:0]  port_dir;                      // port direction
  logic [7:0]  port2_function_select;         // port 2 select
  logic [7:0]  port_cm_function_select;       // clock/wait port select
  logic [7:0]  chipselect_port_function_select; // chip select port select
  logic [7:0]  interrupt_ctrl;                // interrupt control
  logic [15:0] interrupt_mask_word;           // interrupt mask
  logic [15:0] data_wait_setting;             // data wait control
  logic [15:0] chip_area_select_setting;      // chip area select
  logic [15:0] address_setup_wait_setting;    // address setup wait
  logic [7:0]  flash_program_mode_setting;    // flash mode control
  logic [7:0]  converter_mode_second;         // converter mode
  logic [7:0]  pulse_width_control;           // pwm control
  logic [7:0]  capture_timer_mode_second;     // capture timer mode
  logic [15:0] timer_count;                   // timer counter
  logic [7:0]  flpm_rst;                      // flash mode reset value
  logic [7:0]  pmcm_rst;                      // clock port select reset value
  logic [7:0]  pmcs_rst;                      // cs port select reset value

  // =====================================
  // filter and synchroniser
  src_filter #(
    .FILT_CYC (`SRC_FILT_CYC)
  ) u_filter (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .rst_pin_n (rst_pin_n),
    .rst_req   (hold)
  );

  // =====================================
  // sequencer
  // stay while held
  always_comb begin
    case (state)
      SRC_HOLD: next_state = hold ? SRC_HOLD : SRC_RUN;
      SRC_RUN:  next_state = hold ? SRC_HOLD : SRC_RUN;
      default:  next_state = SRC_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= SRC_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fetch_start  <= 1'b0;
      core_reset_n <= 1'b0;
    end else begin
      fetch_start  <= (state == SRC_HOLD) && (next_state == SRC_RUN);
      core_reset_n <= (next_state == SRC_RUN);
    end
  end

  // mode strap caught while held
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode <= SRC_SC0;
    end else if (hold) begin
      mode <= src_mode_t'(mode_strap);
    end
  end

  // =====================================
  // pin states
  // pins float in reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_hiz        <= 1'b1;
      bus_port_mode  <= 1'b1;
      bus_ports_ctrl <= 1'b0;
    end else begin
      pin_hiz        <= (next_state == SRC_HOLD);
      bus_port_mode  <= (mode == SRC_SC0);
      bus_ports_ctrl <= (mode != SRC_SC0);
    end
  end

  // clock pin divides core clock by two
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clock_output_pin <= 1'b0;
    end else begin
      clock_output_pin <= ~clock_output_pin;
    end
  end

  assign clock_output_oe_n = (mode == SRC_SC0) && !port_cm_function_select[`SRC_PMCM_CLK_BIT];

  // =====================================
  // mode dependent reset values
  // bus select by mode
  always_comb begin
    pmcm_rst = (mode == SRC_SC0) ? `SRC_PMC_RST : `SRC_PMCM_BUS_RST;
    pmcs_rst = (mode == SRC_SC0) ? `SRC_PMC_RST : `SRC_PMCS_BUS_RST;
    if (!FLASH_PART) begin
      flpm_rst = `SRC_FLPM_ROM_RST;
    end else if (mode == SRC_SC0) begin
      flpm_rst = `SRC_FLPM_SC0_RST;
    end else begin
      flpm_rst = `SRC_FLPM_OTH_RST;
    end
  end

  assign wr_ok = sw_wr && core_reset_n;

  // =====================================
  // cpu registers
  // cpu reset values
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !core_reset_n) begin
      program_counter       <= `SRC_PC_RST;
      interrupt_source_code <= `SRC_ISC_RST;
      processor_status_word <= `SRC_PSW_RST;
    end else if (wr_ok) begin
      case (src_reg_t'(sw_sel))
        SRC_R_PC:  program_counter       <= sw_data;
        SRC_R_ISC: interrupt_source_code <= sw_data;
        SRC_R_PSW: processor_status_word <= sw_data;
        default: ;
      endcase
    end
  end

  // =====================================
  // port registers
  // port reset values
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !core_reset_n) begin
      port_dir                        <= `SRC_PDIR_RST;
      port2_function_select           <= `SRC_PORT2_FUNCTION_SELECT_RST;
      port_cm_function_select         <= pmcm_rst;
      chipselect_port_function_select <= pmcs_rst;
    end else if (wr_ok) begin
      case (src_reg_t'(sw_sel))
        SRC_R_PDIR: port_dir                        <= sw_data[7:0];
        SRC_R_PORT2_FUNCTION_SELECT: port2_function_select           <= sw_data[7:0];
        SRC_R_PMCM: port_cm_function_select         <= sw_data[7:0];
        SRC_R_PMCS: chipselect_port_function_select <= sw_data[7:0];
        default: ;
      endcase
    end
  end

  // =====================================
  // interrupt and bus registers
  // interrupts masked
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !core_reset_n) begin
      interrupt_ctrl             <= `SRC_INTC_RST;
      interrupt_mask_word        <= `SRC_IMR_RST;
      data_wait_setting          <= `SRC_DWC_RST;
      chip_area_select_setting   <= `SRC_CSC_RST;
      address_setup_wait_setting <= `SRC_ASC_RST;
    end else if (wr_ok) begin
      case (src_reg_t'(sw_sel))
        SRC_R_INTC: interrupt_ctrl             <= sw_data[7:0];
        SRC_R_IMR:  interrupt_mask_word        <= sw_data[15:0];
        SRC_R_DWC:  data_wait_setting          <= sw_data[15:0];
        SRC_R_CSC:  chip_area_select_setting   <= sw_data[15:0];
        SRC_R_ASC:  address_setup_wait_setting <= sw_data[15:0];
        default: ;
      endcase
    end
  end

  // =====================================
  // peripheral registers
  // converter and pwm
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !core_reset_n) begin
      flash_program_mode_setting <= flpm_rst;
      converter_mode_second      <= `SRC_CONVERTER_MODE_SECOND_RST;
      pulse_width_control        <= `SRC_PWMC_RST;
      capture_timer_mode_second  <= `SRC_TMC1_RST;
      timer_count                <= `SRC_TCNT_RST;
    end else if (wr_ok) begin
      case (src_reg_t'(sw_sel))
        SRC_R_FLPM: flash_program_mode_setting <= sw_data[7:0];
        SRC_R_PERI: begin
          converter_mode_second     <= sw_data[7:0];
          pulse_width_control       <= sw_data[15:8];
          capture_timer_mode_second <= sw_data[23:16];
        end
        SRC_R_TCNT: timer_count <= sw_data[15:0];
        default: ;
      endcase
    end
  end

  // =====================================
  // contents of undefined registers
  // lost on power-on or torn write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      contents_kept <= 1'b0;
    end else if (hold && core_reset_n && sync_wr_busy) begin
      contents_kept <= 1'b0;
    end else if (wr_ok) begin
      contents_kept <= 1'b1;
    end
  end

  // =====================================
  // read back
  // register zero reads zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data <= 32'h0000_0000;
    end else begin
      case (src_reg_t'(sw_sel))
        SRC_R_PC:   rd_data <= program_counter;
        SRC_R_ISC:  rd_data <= interrupt_source_code;
        SRC_R_PSW:  rd_data <= processor_status_word;
        SRC_R_PDIR: rd_data <= {24'h000000, port_dir};
        SRC_R_PORT2_FUNCTION_SELECT: rd_data <= {24'h000000, port2_function_select};
        SRC_R_PMCM: rd_data <= {24'h000000, port_cm_function_select};
        SRC_R_PMCS: rd_data <= {24'h000000, chipselect_port_function_select};
        SRC_R_INTC: rd_data <= {24'h000000, interrupt_ctrl};
        SRC_R_IMR:  rd_data <= {16'h0000, interrupt_mask_word};
        SRC_R_DWC:  rd_data <= {16'h0000, data_wait_setting};
        SRC_R_CSC:  rd_data <= {16'h0000, chip_area_select_setting};
        SRC_R_ASC:  rd_data <= {16'h0000, address_setup_wait_setting};
        SRC_R_FLPM: rd_data <= {24'h000000, flash_program_mode_setting};
        SRC_R_PERI: rd_data <= {8'h00, capture_timer_mode_second, pulse_width_control, converter_mode_second};
        SRC_R_TCNT: rd_data <= {16'h0000, timer_count};
        SRC_R_GPR0: rd_data <= `SRC_GPR0_RST;
        default:    rd_data <= 32'h0000_0000;
      endcase
    end
  end

  // =====================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_release;
    hold ##1 !hold;
  endsequence

  a_hold_reset: assert property (hold |=> !core_reset_n && pin_hiz)
    else $error("reset not held");
  a_fetch_pulse: assert property (s_release |=> fetch_start ##1 !fetch_start)
    else $error("fetch pulse wrong");
  a_pins_hiz: assert property (!core_reset_n |-> pin_hiz)
    else $error("pins driven in reset");
  a_clk_other: assert property (mode != SRC_SC0 |-> !clock_output_oe_n)
    else $error("clock pin not driven");
  a_clk_sc0: assert property (mode == SRC_SC0 && !port_cm_function_select[1] |-> clock_output_oe_n)
    else $error("clock pin driven too early");
  a_bus_mode: assert property (!core_reset_n |=> bus_port_mode == (mode == SRC_SC0))
    else $error("bus pin mode wrong");
  a_cpu_reset: assert property (fetch_start |-> processor_status_word == 32'h0000_0020
    && program_counter == 32'h0)
    else $error("cpu reset values wrong");
  a_port_select: assert property (fetch_start |->
    port_cm_function_select == ((mode == SRC_SC0) ? 8'h00 : 8'h3F))
    else $error("port select reset wrong");
  a_mask_reset: assert property (fetch_start |-> interrupt_mask_word == 16'hFFFF && interrupt_ctrl == 8'h47)
    else $error("interrupt reset wrong");
  a_bus_reset: assert property (fetch_start |-> data_wait_setting == 16'h7777
    && chip_area_select_setting == 16'h2C11)
    else $error("bus controller reset wrong");
endmodule // src_reset_ctrl
`default_nettype wire

// ==== src_rst_source.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
// external reset source and attached memory
module src_rst_source #(
  parameter int OSC_CYC = 8          // power-up low cycles
) (
  input  wire logic sys_clk,         // core clock
  input  wire logic low_req,         // hold pin low
  input  wire logic glitch_req,      // rising edge makes a glitch
  input  wire logic pin_hiz,         // device pins floating
  input  wire logic core_reset_n,    // device reset state
  output var  logic rst_pin_n,       // reset pin level
  output var  logic mem_bad          // memory saw driven bus in reset
);
  int   osc_cnt = 0;                 // power-up counter
  logic glitch  = 1'b0;              // short low in progress
  always @(negedge sys_clk) begin
    if (osc_cnt < OSC_CYC) begin
      osc_cnt <= osc_cnt + 1;
    end
  end
  // 30 ns low, between rising edges
  always @(posedge glitch_req) begin
    glitch = 1'b1;
    #30;
    glitch = 1'b0;
  end
  // pin level from all low causes
  always_comb begin
    rst_pin_n = !(osc_cnt < OSC_CYC || low_req || glitch);
  end
  // memory damaged if bus driven in reset, clear at power-up
  always @(posedge sys_clk) begin
    if (osc_cnt == 0) begin
      mem_bad <= 1'b0;
    end else if (!core_reset_n && !pin_hiz) begin
      mem_bad <= 1'b1;
    end
  end
endmodule // src_rst_source
`default_nettype wire

// ==== src_reset_ctrl_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "src_cfg.svh"
`define TB_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
// ==========
// bench top
module src_reset_ctrl_tb_top import src_pkg::*;;
  logic        sys_clk      = 1'b0;   // core clock
  logic        reset_n      = 1'b0;   // block reset
  logic [1:0]  mode_strap   = 2'b00;  // operating mode
  logic        sync_wr_busy = 1'b0;   // write underway
  logic        sw_wr        = 1'b0;   // write strobe
  logic [3:0]  sw_sel       = 4'h0;   // register select
  logic [31:0] sw_data      = 32'h0;  // write data
  logic        low_req      = 1'b0;   // partner hold request
  logic        glitch_req   = 1'b0;   // partner glitch request
  logic        rst_pin_n;             // reset pin
  logic        mem_bad;               // memory hazard flag
  logic [31:0] rd_data;               // read data
  logic        core_reset_n;          // chip reset
  logic        fetch_start;           // fetch pulse
  logic        pin_hiz;               // pins floating
  logic        bus_port_mode;         // bus pins ports
  logic        bus_ports_ctrl;        // bus ports control
  logic        clock_output_pin;      // clock pin
  logic        clock_output_oe_n;     // clock pin enable
  logic        contents_kept;         // undefined regs valid
  int          num_errors   = 0;      // mismatches
  int          checked      = 0;      // comparisons
  int          cycles       = 0;      // timeout counter
  // ==========
  // clock and timeout
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========
  // design and partner
  src_reset_ctrl #(.FLASH_PART(1'b1)) i_src_reset_ctrl (
    .sys_clk(sys_clk), .reset_n(reset_n), .rst_pin_n(rst_pin_n),
    .mode_strap(mode_strap), .sync_wr_busy(sync_wr_busy), .sw_wr(sw_wr),
    .sw_sel(sw_sel), .sw_data(sw_data), .rd_data(rd_data),
    .core_reset_n(core_reset_n), .fetch_start(fetch_start), .pin_hiz(pin_hiz),
    .bus_port_mode(bus_port_mode), .bus_ports_ctrl(bus_ports_ctrl),
    .clock_output_pin(clock_output_pin), .clock_output_oe_n(clock_output_oe_n),
    .contents_kept(contents_kept)
  );
  src_rst_source #(.OSC_CYC(8)) i_src_rst_source (
    .sys_clk(sys_clk), .low_req(low_req), .glitch_req(glitch_req),
    .pin_hiz(pin_hiz), .core_reset_n(core_reset_n),
    .rst_pin_n(rst_pin_n), .mem_bad(mem_bad)
  );
  // ==========
  // expected values
  function automatic logic [31:0] exp_rst(input logic [3:0] s, input logic [1:0] m);
    case (src_reg_t'(s))
      SRC_R_PSW:  return 32'h20;
      SRC_R_PDIR: return 32'hFF;
      SRC_R_PORT2_FUNCTION_SELECT: return 32'h01;
      SRC_R_PMCM: return (m == 2'b00) ? 32'h00 : 32'h3F;
      SRC_R_PMCS: return (m == 2'b00) ? 32'h00 : 32'hFF;
      SRC_R_INTC: return 32'h47;
      SRC_R_IMR:  return 32'hFFFF;
      SRC_R_DWC:  return 32'h7777;
      SRC_R_CSC:  return 32'h2C11;
      SRC_R_ASC:  return 32'hFFFF;
      SRC_R_FLPM: return (m == 2'b00) ? 32'h08 : 32'h0C;
      SRC_R_PERI: return 32'h0020_4007;
      default:    return 32'h0;
    endcase
  endfunction
  // writable bits of each register
  function automatic logic [31:0] msk(input logic [3:0] s);
    case (src_reg_t'(s))
      SRC_R_PC, SRC_R_ISC, SRC_R_PSW:           return 32'hFFFF_FFFF;
      SRC_R_IMR, SRC_R_DWC, SRC_R_CSC:          return 32'hFFFF;
      SRC_R_ASC, SRC_R_TCNT:                    return 32'hFFFF;
      SRC_R_PERI:                               return 32'hFF_FFFF;
      SRC_R_GPR0:                               return 32'h0;
      default:                                  return 32'hFF;
    endcase
  endfunction
  // ==========
  // port tasks
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(negedge sys_clk);
    sw_wr   = 1'b1;
    sw_sel  = s;
    sw_data = d;
    @(negedge sys_clk);
    sw_wr   = 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] s, input logic [31:0] e);
    @(negedge sys_clk);
    sw_sel = s;
    @(negedge sys_clk);
    `TB_CHK(rd_data, e)
  endtask
  // negedges until core_reset_n reaches want
  task automatic cnt_until(input logic want, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (core_reset_n !== want && n < 20);
  endtask
  task automatic print_verdict();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    int          n;   // cycle count
    logic [31:0] d;   // random data
    logic        c0;  // earlier clock pin level
    void'($urandom(32'heedc));
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    cnt_until(1'b1, n);
    `TB_CHK(fetch_start, 1'b1)
    `TB_CHK(contents_kept, 1'b0)
    for (int m = 0; m < 4; m++) begin
      mode_strap = m[1:0];
      d = $urandom;
      wr(SRC_R_TCNT, d);
      `TB_CHK(contents_kept, 1'b1)
      sync_wr_busy = m[0];
      low_req = 1'b1;
      cnt_until(1'b0, n);
      // filter, two sync stages, then the sequencer flop
      `TB_CHK(n, `SRC_FILT_CYC + 3)
      `TB_CHK(pin_hiz, 1'b1)
      `TB_CHK(clock_output_oe_n, m == 0)
      `TB_CHK(contents_kept, !m[0])
      c0 = clock_output_pin;
      @(negedge sys_clk);
      if (m != 0) `TB_CHK(clock_output_pin, ~c0)
      // strap is caught one edge into reset, pin state one edge later
      `TB_CHK(bus_port_mode, m == 0)
      `TB_CHK(bus_ports_ctrl, m != 0)
      low_req = 1'b0;
      cnt_until(1'b1, n);
      // high clears filter at once, two sync stages, sequencer flop
      `TB_CHK(n, 4)
      `TB_CHK(fetch_start, 1'b1)
      sync_wr_busy = 1'b0;
      @(negedge sys_clk);
      `TB_CHK(fetch_start, 1'b0)
      `TB_CHK(mem_bad, 1'b0)
      for (int s = 0; s < 16; s++) rd_chk(s[3:0], exp_rst(s[3:0], m[1:0]));
      // random writes read back
      for (int s = 0; s < 16; s++) begin
        d = $urandom;
        wr(s[3:0], d);
        rd_chk(s[3:0], d & msk(s[3:0]));
        if (s == SRC_R_PMCM && m == 0) `TB_CHK(clock_output_oe_n, ~d[1])
      end
    end
    // short lows must not reset
    for (int i = 0; i < 18; i++) begin
      @(negedge sys_clk);
      glitch_req = (i < 12) ? ~glitch_req : 1'b0;
      `TB_CHK(core_reset_n, 1'b1)
    end
    // block reset drops kept contents
    @(negedge sys_clk);
    reset_n = 1'b0;
    @(negedge sys_clk);
    reset_n = 1'b1;
    `TB_CHK(contents_kept, 1'b0)
    print_verdict();
  end
endmodule // src_reset_ctrl_tb_top
`default_nettype wire
